/* verilog/dspl_serial_core.sv */
`timescale 1ns/1ps
`default_nettype none
module dspl_serial_core (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Device pins.
  input  wire logic        sclk,
  input  wire logic        frame_n,
  input  wire logic        serial_in,
  input  wire logic        update_strobe_n,
  input  wire logic        reset_n,
  output logic             serial_out,
  // Converter side.
  output logic [15:0]      input_reg,
  output logic [15:0]      dac_reg,
  output logic             output_clamped,
  output logic             dac_loaded
);

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  dspl_sync_if sy ();

  dspl_pin_sync u_sync (
    .sys_clk         (sys_clk),
    .sys_rst         (sys_rst),
    .sclk            (sclk),
    .frame_n         (frame_n),
    .serial_in       (serial_in),
    .update_strobe_n (update_strobe_n),
    .sy              (sy)
  );

  // Reset pin synchroniser, idle high as with its pull-up.
  logic [1:0] rst_sync_ff;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_sync_ff <= 2'h3;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], reset_n};
    end
  end

  // ********************************************************************
  // State
  // ********************************************************************
  typedef enum logic [1:0] {IDLE, SHIFT, ACT} dspl_phase_type;

  typedef struct packed {
    dspl_phase_type   phase;
    logic [23:0]      shreg;
    logic [23:0]      outreg;
    logic [4:0]       bits;
    logic             sout;
    logic [15:0]      inreg;
    logic [15:0]      dac;
    logic             pending;
    logic             clamped;
    logic             loaded;
  } dspl_core_type;

  dspl_core_type st_ff;
  dspl_core_type nxt_st;

  logic [3:0] cmd;

  assign cmd = st_ff.shreg[dspl_pkg::CMD_POS +: dspl_pkg::CMD_BITS];

  // Frame sequencing, shifting, command decode and update logic.
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.loaded = 1'b0;
    if (!rst_sync_ff[1]) begin
      nxt_st.phase   = IDLE;
      nxt_st.shreg   = '0;
      nxt_st.outreg  = '0;
      nxt_st.bits    = '0;
      nxt_st.sout    = 1'b0;
      nxt_st.inreg   = dspl_pkg::INPUT_RST;
      nxt_st.dac     = dspl_pkg::DAC_RST;
      nxt_st.pending = 1'b0;
      nxt_st.clamped = 1'b1;
    end else begin
      case (st_ff.phase)
        IDLE: begin
          if (sy.frame_start) begin
            nxt_st.phase = SHIFT;
            nxt_st.bits  = '0;
          end
        end
        SHIFT: begin
          if (sy.frame_end) begin
            nxt_st.phase = ACT;
          end else if (sy.sclk_fall) begin
            nxt_st.shreg = {st_ff.shreg[22:0], sy.serial_in_lvl};
            if (st_ff.bits != 5'(dspl_pkg::WORD_BITS)) begin
              nxt_st.bits = st_ff.bits + 5'h01;
            end
          end else if (sy.sclk_rise) begin
            nxt_st.sout   = st_ff.outreg[23];
            nxt_st.outreg = {st_ff.outreg[22:0], 1'b0};
          end
        end
        ACT: begin
          nxt_st.phase  = IDLE;
          nxt_st.outreg = st_ff.shreg; // Daisy-chain: last word shifts on.
          if (st_ff.bits == 5'(dspl_pkg::WORD_BITS)) begin
            if (cmd == dspl_pkg::CMD_WR_INPUT) begin
              nxt_st.inreg = st_ff.shreg[15:0];
              if (!sy.strobe_lvl) begin
                nxt_st.dac     = st_ff.shreg[15:0];
                nxt_st.loaded  = 1'b1;
                nxt_st.clamped = 1'b0;
              end else begin
                nxt_st.pending = 1'b1;
              end
            end else if (cmd == dspl_pkg::CMD_UPDATE) begin
              nxt_st.dac     = st_ff.inreg;
              nxt_st.loaded  = 1'b1;
              nxt_st.clamped = 1'b0;
              nxt_st.pending = 1'b0;
            end else if (cmd == dspl_pkg::CMD_WR_UPDATE) begin
              nxt_st.inreg   = st_ff.shreg[15:0];
              nxt_st.dac     = st_ff.shreg[15:0];
              nxt_st.loaded  = 1'b1;
              nxt_st.clamped = 1'b0;
              nxt_st.pending = 1'b0;
            end else if (cmd == dspl_pkg::CMD_READBACK) begin
              nxt_st.outreg = {dspl_pkg::CMD_READBACK, 4'h0, st_ff.dac};
            end
          end
        end
        default: nxt_st.phase = IDLE;
      endcase
      // Deferred copy on the strobe's falling edge.
      if (st_ff.pending && sy.strobe_fall && st_ff.phase != ACT) begin
        nxt_st.dac     = st_ff.inreg;
        nxt_st.pending = 1'b0;
        nxt_st.loaded  = 1'b1;
        nxt_st.clamped = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '{phase: IDLE, shreg: '0, outreg: '0, bits: '0, sout: 1'b0,
                 inreg: dspl_pkg::INPUT_RST, dac: dspl_pkg::DAC_RST,
                 pending: 1'b0, clamped: 1'b1, loaded: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state flops.
  assign serial_out     = st_ff.sout;
  assign input_reg      = st_ff.inreg;
  assign dac_reg        = st_ff.dac;
  assign output_clamped = st_ff.clamped;
  assign dac_loaded     = st_ff.loaded;

endmodule // dspl_serial_core
`default_nettype wire

/* verilog/dspl_pkg.sv */
// Contract
// - While frame select is low, one serial input bit is shifted in at each falling serial clock edge.
// - The shifted word is acted on only when frame select rises, ending the frame.
// - In readback or daisy-chain use the serial output changes on rising clock edges, valid at the next fall.
// - With the update strobe held low, the converter register follows each input register write at once.
// - With the update strobe high during a write, the copy waits for the strobe's next falling edge; the code ignores a fall in the cycle a frame is acted on.
// - An unconnected update strobe reads high, so writes are then deferred.
// - While the active-low reset is asserted, all state returns to power-on defaults with output clamped.
`default_nettype none
package dspl_pkg;

  // ********************************************************************
  // Frame layout
  // ********************************************************************
  localparam int unsigned WORD_BITS  = 24;
  localparam int unsigned DATA_BITS  = 16;
  localparam int unsigned CMD_POS    = 20;
  localparam int unsigned CMD_BITS   = 4;
  localparam int unsigned CNT_BITS   = 5;

  // Command codes kept neutral; the frame's command nibble selects the action.
  localparam logic [3:0] CMD_NOP       = 4'h0;
  localparam logic [3:0] CMD_WR_INPUT  = 4'h1;
  localparam logic [3:0] CMD_UPDATE    = 4'h2;
  localparam logic [3:0] CMD_WR_UPDATE = 4'h3;
  localparam logic [3:0] CMD_READBACK  = 4'hB;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [15:0] INPUT_RST = 16'h0000;
  localparam logic [15:0] DAC_RST   = 16'h0000;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned SYS_CLK_HZ  = 50_000_000;
  localparam int unsigned LINK_MAX_HZ = 50_000_000;

endpackage
`default_nettype wire

/* verilog/dspl_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Synchronised pin levels and their edge pulses, shared by the synchroniser and the core.
interface dspl_sync_if;
  logic sclk_lvl;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_n_lvl;
  logic frame_start;
  logic frame_end;
  logic serial_in_lvl;
  logic strobe_fall;
  logic strobe_lvl;

  modport src (output sclk_lvl, sclk_rise, sclk_fall, frame_n_lvl, frame_start, frame_end,
               serial_in_lvl, strobe_fall, strobe_lvl);
  modport dst (input sclk_lvl, sclk_rise, sclk_fall, frame_n_lvl, frame_start, frame_end,
               serial_in_lvl, strobe_fall, strobe_lvl);
endinterface
`default_nettype wire

/* verilog/dspl_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dspl_pin_sync (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Raw pins.
  input  wire logic sclk,
  input  wire logic frame_n,
  input  wire logic serial_in,
  input  wire logic update_strobe_n,
  // Synchronised levels and edges.
  dspl_sync_if.src  sy
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
  } dspl_sync_type;

  dspl_sync_type st_ff;
  dspl_sync_type nxt_st;

  // Two flops per pin, then a third copy for edge detection.
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = {update_strobe_n, serial_in, frame_n, sclk};
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  // Pins reset to their idle levels, so no false edge follows reset: link clock low,
  // frame select high, and strobe high as its pull-up holds it.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '{s1: 4'hA, s2: 4'hA, s3: 4'hA};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Levels and edges seen from the second flop onward.
  assign sy.sclk_lvl      = st_ff.s2[0];
  assign sy.sclk_rise     = st_ff.s2[0] & ~st_ff.s3[0];
  assign sy.sclk_fall     = ~st_ff.s2[0] & st_ff.s3[0];
  assign sy.frame_n_lvl   = st_ff.s2[1];
  assign sy.frame_start   = ~st_ff.s2[1] & st_ff.s3[1];
  assign sy.frame_end     = st_ff.s2[1] & ~st_ff.s3[1];
  assign sy.serial_in_lvl = st_ff.s2[2];
  assign sy.strobe_fall   = ~st_ff.s2[3] & st_ff.s3[3];
  assign sy.strobe_lvl    = st_ff.s2[3];

endmodule // dspl_pin_sync
`default_nettype wire

/* tb/dspl_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Serial master model; the link clock stands low between frames.
module dspl_host (
  // Clock.
  input  wire logic sys_clk,
  // Serial pins.
  output var logic  sclk,
  output var logic  frame_n,
  output var logic  serial_in,
  input  wire logic serial_out
);
  // Idle levels before the first frame.
  initial begin
    sclk = 1'b0;
    frame_n = 1'b1;
    serial_in = 1'b0;
  end
  // Half a 160 ns bit period, landing just past a system clock edge.
  task automatic half();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // Sends the low n bits of w MSB first and returns what came back.
  task automatic send(input logic [23:0] w, input int n, output logic [23:0] r);
    r = 24'h000000;
    frame_n = 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      serial_in = w[i];
      half();
      r = {r[22:0], serial_out};
      sclk = 1'b0;
      half();
    end
    frame_n = 1'b1;
    serial_in = ~serial_in;
    half();
    half();
  endtask
endmodule // dspl_host
`default_nettype wire

/* tb/dspl_serial_core_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the pins and converter registers of the serial core.
module dspl_serial_core_chk (
  // Clock, reset and pins.
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        sclk,
  input wire logic        frame_n,
  input wire logic        serial_in,
  input wire logic        update_strobe_n,
  input wire logic        reset_n,
  input wire logic        serial_out,
  // Converter side.
  input wire logic [15:0] input_reg,
  input wire logic [15:0] dac_reg,
  input wire logic        output_clamped,
  input wire logic        dac_loaded
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Register loads tied to frame end, strobe level and device reset; serial output tied to the link clock.
  AST_ACT_AT_END: assert property (
    $changed(input_reg) && reset_n |-> frame_n && $past(frame_n, 2))
    else $error("Input register changed inside a frame.");
  AST_IDLE_QUIET: assert property (
    frame_n [*8] ##0 reset_n |-> $stable(input_reg))
    else $error("Input register changed with no frame.");
  AST_FOLLOW: assert property (
    $changed(input_reg) && reset_n && !update_strobe_n |-> dac_reg == input_reg)
    else $error("Converter register missed an immediate load.");
  AST_LOAD_COPY: assert property (
    dac_loaded |-> dac_reg == input_reg)
    else $error("Load did not copy the input register.");
  AST_HELD_OFF: assert property (
    $changed(dac_reg) && reset_n |-> !update_strobe_n)
    else $error("Converter register changed with the strobe high.");
  AST_RST_STATE: assert property (
    !reset_n [*4] |-> input_reg == 16'h0000 && dac_reg == 16'h0000 && output_clamped)
    else $error("Device reset did not restore defaults.");
  AST_UNCLAMP: assert property (
    $fell(output_clamped) |-> dac_loaded || $past(dac_loaded))
    else $error("Clamp released without a load.");
  AST_OUT_EDGE: assert property (
    $changed(serial_out) && reset_n |-> sclk || frame_n)
    else $error("Serial output changed while the link clock was low.");
  // Main scenarios.
  cover property ($fell(update_strobe_n) ##[1:6] dac_loaded);
  cover property ($rose(frame_n) ##[1:6] $changed(input_reg));
  cover property ($fell(reset_n));
endmodule // dspl_serial_core_chk
bind dspl_serial_core dspl_serial_core_chk i_chk (.sys_clk, .sys_rst, .sclk, .frame_n,
  .serial_in, .update_strobe_n, .reset_n, .serial_out, .input_reg, .dac_reg,
  .output_clamped, .dac_loaded);
`default_nettype wire

/* tb/dspl_serial_core_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dspl_serial_core_test;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        update_strobe_n = 1'b0;
  logic        reset_n = 1'b1;
  logic        sclk, frame_n, serial_in, serial_out;
  logic [15:0] input_reg, dac_reg;
  logic        output_clamped, dac_loaded;
  logic [23:0] rx;
  int          miscompares = 0;
  int          tests_run = 0;
  int          loads = 0;
  // Free-running 50 MHz system clock.
  always #10 sys_clk = ~sys_clk;
  // Counts the one-cycle converter load pulses.
  always @(posedge sys_clk) if (dac_loaded === 1'b1) loads++;
  dspl_host i_host (.sys_clk, .sclk, .frame_n, .serial_in, .serial_out);
  dspl_serial_core i_dut (.sys_clk, .sys_rst, .sclk, .frame_n, .serial_in,
    .update_strobe_n, .reset_n, .serial_out, .input_reg, .dac_reg,
    .output_clamped, .dac_loaded);
  // Compares one value and counts the result.
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Lets a frame end or a strobe edge work through the pin syncs.
  task automatic settle();
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Strobe low: converter follows the write.
  task automatic t_write_now();
    update_strobe_n = 1'b0;
    i_host.send(24'h10A5C3, 24, rx);
    settle();
    check({8'h00, input_reg}, 24'h00A5C3);
    check({8'h00, dac_reg}, 24'h00A5C3);
    check(24'(loads), 24'h000001);
    check({23'h0, output_clamped}, 24'h000000);
  endtask
  // Strobe high: load waits for the strobe's fall.
  task automatic t_deferred();
    update_strobe_n = 1'b1;
    i_host.send(24'h103C5A, 24, rx);
    settle();
    check({8'h00, input_reg}, 24'h003C5A);
    check({8'h00, dac_reg}, 24'h00A5C3);
    check(24'(loads), 24'h000001);
    update_strobe_n = 1'b0;
    settle();
    check({8'h00, dac_reg}, 24'h003C5A);
    check(24'(loads), 24'h000002);
  endtask
  // Daisy data, then readback of the converter register.
  task automatic t_readback();
    i_host.send(24'hB00000, 24, rx);
    check(rx, 24'h103C5A);
    i_host.send(24'h000000, 24, rx);
    check(rx, 24'hB03C5A);
  endtask
  // A short frame is dropped and the next frame counts afresh.
  task automatic t_short();
    i_host.send(24'h000123, 12, rx);
    settle();
    check({8'h00, input_reg}, 24'h003C5A);
    i_host.send(24'h101234, 24, rx);
    settle();
    check({8'h00, input_reg}, 24'h001234);
    check(24'(loads), 24'h000003);
  endtask
  // Device reset pin restores defaults with the output clamped.
  task automatic t_reset();
    reset_n = 1'b0;
    settle();
    check({8'h00, input_reg}, 24'h000000);
    check({8'h00, dac_reg}, 24'h000000);
    check({23'h0, output_clamped}, 24'h000001);
    reset_n = 1'b1;
    settle();
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    settle();
    check({23'h0, output_clamped}, 24'h000001);
    t_write_now();
    t_deferred();
    t_readback();
    t_short();
    t_reset();
    close_out();
  end
  // Watchdog well past the expected run of about 24 us.
  initial begin
    #200_000;
    miscompares++;
    close_out();
  end
endmodule // dspl_serial_core_test
`default_nettype wire
